// File: shared/lps_params.svh
// offsets, field positions, reset values and timing counts of the sensor regs
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define LPS_OFF_CONFIG 8'h0d
`define LPS_OFF_PULSES 8'h0e
`define LPS_OFF_CONTROL 8'h0f
`define LPS_OFF_IDENT 8'h12
`define LPS_OFF_STATUS 8'h13
`define LPS_OFF_CH0_LO 8'h14
`define LPS_OFF_CH0_HI 8'h15
`define LPS_OFF_CH1_LO 8'h16
`define LPS_OFF_CH1_HI 8'h17
`define LPS_OFF_PROX_LO 8'h18
`define LPS_OFF_PROX_HI 8'h19

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define LPS_CFG_DRIVE_REDUCE 0
`define LPS_CFG_WAIT_EXTEND 1
`define LPS_CFG_SCALE_DOWN 2
`define LPS_CTL_DRIVE_HI 7
`define LPS_CTL_DRIVE_LO 6
`define LPS_CTL_DIODE_HI 5
`define LPS_CTL_DIODE_LO 4
`define LPS_CTL_PROX_GAIN_HI 3
`define LPS_CTL_PROX_GAIN_LO 2
`define LPS_CTL_LGAIN_HI 1
`define LPS_CTL_LGAIN_LO 0
`define LPS_ST_PROX_SAT 6
`define LPS_ST_PROX_IRQ 5
`define LPS_ST_LIGHT_IRQ 4
`define LPS_ST_PROX_READY 1
`define LPS_ST_LIGHT_READY 0
`define LPS_DIODE_CH1 2'h2

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define LPS_CONFIG_RST 3'h0
`define LPS_PULSES_RST 8'h08
`define LPS_CONTROL_RST 8'h20
// arbitrary identity value, not tied to any real part
`define LPS_IDENT_DEFAULT 8'h5a

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define LPS_CLK_HZ 40000000
`define LPS_PULSE_RATE_HZ 62500
`define LPS_PULSE_CYCLES (`LPS_CLK_HZ / `LPS_PULSE_RATE_HZ)
`define LPS_WAIT_STEP_US 2730
`define LPS_WAIT_STEP_CYCLES (`LPS_WAIT_STEP_US * (`LPS_CLK_HZ / 1000000))
`define LPS_WAIT_EXTEND 12

`endif

// File: shared/lps_pkg.sv
// state types of the light and proximity sensor register block
package lps_pkg;

	typedef enum logic [1:0]
	{
		LPS_W_IDLE = 2'b01,
		LPS_W_RUN = 2'b10
	} lps_wait_st_t;

	typedef enum logic [2:0]
	{
		LPS_P_IDLE = 3'b001,
		LPS_P_HIGH = 3'b010,
		LPS_P_LOW = 3'b100
	} lps_pulse_st_t;

	typedef struct packed {
		logic [2:0] cfg;
		logic [7:0] pulses;
		logic [7:0] ctrl;
		logic [15:0] ch0;
		logic [15:0] ch1;
		logic [15:0] prox;
		logic [7:0] sh0;
		logic [7:0] sh1;
		logic [7:0] shp;
		logic [7:0] rdata;
		logic [16:0] led_ua;
		logic [13:0] lgain;
		logic [3:0] prox_gain;
		logic diode_ch1;
		logic diode_bad;
		lps_wait_st_t wst;
		logic [11:0] wsteps;
		logic [16:0] wtick;
		logic wait_done;
	} lps_regs_t;

	typedef struct packed {
		lps_pulse_st_t st;
		logic [7:0] left;
		logic [9:0] cnt;
		logic pin;
		logic done;
	} lps_pulser_t;

endpackage : lps_pkg

// File: rtl/lps_led_pulser.sv
// led pulse burst generator for the proximity accumulation state
`timescale 1ns/1ps
`include "lps_params.svh"

module lps_led_pulser #(
	parameter int PERIOD = `LPS_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] pulse_count,
	output logic led_drive_pin,
	output logic busy,
	output logic done
);

	localparam logic [9:0] HALF_M1 = 10'(PERIOD / 2 - 1);

	lps_pkg::lps_pulser_t s_q;
	lps_pkg::lps_pulser_t s_d;

	// ------------------------------------------------------------------------
	// burst sequencer
	// ------------------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			lps_pkg::LPS_P_IDLE:
			begin
				if (start)
				begin
					// a zero count ends the burst at once, no light emitted
					if (pulse_count == 8'h00)
						s_d.done = 1'b1;
					else
					begin
						s_d.st = lps_pkg::LPS_P_HIGH;
						s_d.left = pulse_count; // [R5]
						s_d.cnt = 10'h000;
						s_d.pin = 1'b1;
					end
				end
			end
			lps_pkg::LPS_P_HIGH:
			begin
				s_d.cnt = s_q.cnt + 10'h001;
				if (s_q.cnt == HALF_M1)
				begin
					s_d.st = lps_pkg::LPS_P_LOW;
					s_d.cnt = 10'h000;
					s_d.pin = 1'b0;
				end
			end
			lps_pkg::LPS_P_LOW:
			begin
				s_d.cnt = s_q.cnt + 10'h001;
				if (s_q.cnt == HALF_M1)
				begin
					s_d.cnt = 10'h000;
					s_d.left = s_q.left - 8'h01;
					if (s_q.left == 8'h01)
					begin
						s_d.st = lps_pkg::LPS_P_IDLE;
						s_d.done = 1'b1;
					end
					else
					begin
						s_d.st = lps_pkg::LPS_P_HIGH; // [R5]
						s_d.pin = 1'b1;
					end
				end
			end
			default:
				s_d.st = lps_pkg::LPS_P_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.st <= lps_pkg::LPS_P_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign led_drive_pin = s_q.pin;
	assign busy = (s_q.st != lps_pkg::LPS_P_IDLE);
	assign done = s_q.done;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	logic [9:0] hi_len;
	logic [7:0] rises;
	logic [7:0] want;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hi_len <= 10'h000;
			rises <= 8'h00;
			want <= 8'h00;
		end
		else
		begin
			hi_len <= s_q.pin ? hi_len + 10'h001 : 10'h000;
			if (start && !busy)
			begin
				// the first rise lands on the start edge itself
				rises <= {7'h00, s_d.pin};
				want <= pulse_count;
			end
			else if (s_d.pin && !s_q.pin)
				rises <= rises + 8'h01;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_PULSE_WIDTH: assert property ( // [R5]
		$fell(s_q.pin) |-> hi_len == HALF_M1 + 10'h001)
		else $error("led pulse high time differs from half the pulse period");

	AST_PULSE_COUNT: assert property ( // [R5]
		$rose(done) && busy == 1'b0 && $past(busy) |-> rises == want)
		else $error("led burst emitted a wrong number of pulses");

endmodule : lps_led_pulser

// File: rtl/lps_sensor_regs.sv
// register bank of the light/proximity sensor with led burst and wait timer
//
// Behaviour
// R1: host writes zero into configuration bits 7:3.
// R2: scale-down bit scales 1x and 8x light gain by 0.16; avoid higher gain.
// R3: wait-extend bit makes every wait twelve times longer.
// R4: drive field gives 100/50/25/12.5 mA, or 11.1/5.6/2.8/1.4 mA if reduced.
// R5: led pin emits pulse-count pulses at 62.5 kHz during prox accumulation.
// R6: host should use eight pulses at 100 mA.
// R7: only diode code 10 is valid, routing proximity to channel 1 diode.
// R8: proximity gain 1/2/4/8x and light gain 1/8/16/120x from control.
// R9: identity register is read-only and returns a fixed code.
// R10: status register is read-only; bits 7, 3 and 2 carry nothing.
// R11: status bit 6 shows a saturated proximity result.
// R12: status bits 5 and 4 mirror proximity and light interrupts.
// R13: status bits 1 and 0 show proximity and light results completed.
// R14: light channel results held as 16 bits at 0x14/0x15 and 0x16/0x17.
// R15: proximity result held as 16 bits at 0x18/0x19.
// R16: low byte read copies high byte to a shadow, returned by high read.
// R17: host fetches each result by one two-byte auto-increment read.
// R18: wait advances in 2.73 ms steps set by the wait-time value.
// R19: reserved bits read zero; writes to read-only or reserved bits ignored.
`timescale 1ns/1ps
`include "lps_params.svh"

module lps_sensor_regs #(
	parameter int WAIT_STEP_CYCLES = `LPS_WAIT_STEP_CYCLES,
	parameter int PULSE_PERIOD = `LPS_PULSE_CYCLES,
	parameter logic [7:0] PART_ID = `LPS_IDENT_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] ch0_result,
	input wire logic [15:0] ch1_result,
	input wire logic light_update,
	input wire logic [15:0] prox_result,
	input wire logic prox_update,
	input wire logic prox_saturated,
	input wire logic prox_irq_flag,
	input wire logic light_irq_flag,
	input wire logic prox_result_ready,
	input wire logic light_result_ready,
	input wire logic [7:0] wait_time,
	input wire logic wait_start,
	input wire logic prox_accum_start,
	output logic led_drive_pin,
	output logic prox_pulses_done,
	output logic wait_done,
	output logic [16:0] led_current_ua,
	output logic [13:0] light_gain_x100,
	output logic [3:0] prox_gain,
	output logic prox_diode_ch1,
	output logic prox_diode_invalid
);

	localparam logic [16:0] STEP_M1 = 17'(WAIT_STEP_CYCLES - 1);

	lps_pkg::lps_regs_t s_q;
	lps_pkg::lps_regs_t s_d;

	logic [7:0] status_w;
	logic [11:0] wbase;
	logic pulser_busy;

	// ------------------------------------------------------------------------
	// status assembly, reserved bits left at zero
	// ------------------------------------------------------------------------
	always_comb
	begin
		status_w = 8'h00; // [R10]
		status_w[`LPS_ST_PROX_SAT] = prox_saturated; // [R11]
		status_w[`LPS_ST_PROX_IRQ] = prox_irq_flag; // [R12]
		status_w[`LPS_ST_LIGHT_IRQ] = light_irq_flag; // [R12]
		status_w[`LPS_ST_PROX_READY] = prox_result_ready; // [R13]
		status_w[`LPS_ST_LIGHT_READY] = light_result_ready; // [R13]
	end

	// wait-time is two's complement: 0xff is one step, 0x00 is 256
	assign wbase = 12'(9'h100 - {1'b0, wait_time}); // [R18]

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.wait_done = 1'b0;

		// writes; read-only offsets and reserved bits fall through
		if (reg_wr)
		begin
			unique case (reg_addr)
				`LPS_OFF_CONFIG:
					s_d.cfg = reg_wdata[2:0]; // [R19] [R1]
				`LPS_OFF_PULSES:
					s_d.pulses = reg_wdata;
				`LPS_OFF_CONTROL:
					s_d.ctrl = reg_wdata;
				default:
					s_d.cfg = s_q.cfg; // [R9] [R19]
			endcase
		end

		// fresh results only move the live copies, never the shadows
		if (light_update)
		begin
			s_d.ch0 = ch0_result; // [R14]
			s_d.ch1 = ch1_result; // [R14]
		end
		if (prox_update)
			s_d.prox = prox_result; // [R15]

		// reads answer one cycle later; unmapped offsets read zero
		if (reg_rd)
		begin
			unique case (reg_addr)
				`LPS_OFF_CONFIG:
					s_d.rdata = {5'h00, s_q.cfg}; // [R19]
				`LPS_OFF_PULSES:
					s_d.rdata = s_q.pulses;
				`LPS_OFF_CONTROL:
					s_d.rdata = s_q.ctrl;
				`LPS_OFF_IDENT:
					s_d.rdata = PART_ID; // [R9]
				`LPS_OFF_STATUS:
					s_d.rdata = status_w; // [R10]
				`LPS_OFF_CH0_LO:
				begin
					s_d.rdata = s_q.ch0[7:0];
					s_d.sh0 = s_q.ch0[15:8]; // [R16]
				end
				`LPS_OFF_CH0_HI:
					s_d.rdata = s_q.sh0; // [R16]
				`LPS_OFF_CH1_LO:
				begin
					s_d.rdata = s_q.ch1[7:0];
					s_d.sh1 = s_q.ch1[15:8]; // [R16]
				end
				`LPS_OFF_CH1_HI:
					s_d.rdata = s_q.sh1; // [R16]
				`LPS_OFF_PROX_LO:
				begin
					s_d.rdata = s_q.prox[7:0];
					s_d.shp = s_q.prox[15:8]; // [R16]
				end
				`LPS_OFF_PROX_HI:
					s_d.rdata = s_q.shp; // [R16]
				default:
					s_d.rdata = 8'h00; // [R19]
			endcase
		end

		// led current in microamps
		unique case ({s_q.cfg[`LPS_CFG_DRIVE_REDUCE],
			s_q.ctrl[`LPS_CTL_DRIVE_HI:`LPS_CTL_DRIVE_LO]})
			3'h0: s_d.led_ua = 17'h1_86a0; // [R4]
			3'h1: s_d.led_ua = 17'h0_c350;
			3'h2: s_d.led_ua = 17'h0_61a8;
			3'h3: s_d.led_ua = 17'h0_30d4;
			3'h4: s_d.led_ua = 17'h0_2b5c; // [R4]
			3'h5: s_d.led_ua = 17'h0_15e0;
			3'h6: s_d.led_ua = 17'h0_0af0;
			3'h7: s_d.led_ua = 17'h0_0578;
		endcase

		// light gain in hundredths; 16x and 120x are not scaled
		unique case ({s_q.cfg[`LPS_CFG_SCALE_DOWN],
			s_q.ctrl[`LPS_CTL_LGAIN_HI:`LPS_CTL_LGAIN_LO]})
			3'h0: s_d.lgain = 14'h0064; // [R8]
			3'h1: s_d.lgain = 14'h0320;
			3'h2: s_d.lgain = 14'h0640;
			3'h3: s_d.lgain = 14'h2ee0;
			3'h4: s_d.lgain = 14'h0010; // [R2]
			3'h5: s_d.lgain = 14'h0080; // [R2]
			3'h6: s_d.lgain = 14'h0640;
			3'h7: s_d.lgain = 14'h2ee0;
		endcase

		s_d.prox_gain = 4'h1
			<< s_q.ctrl[`LPS_CTL_PROX_GAIN_HI:`LPS_CTL_PROX_GAIN_LO]; // [R8]
		s_d.diode_ch1 = (s_q.ctrl[`LPS_CTL_DIODE_HI:`LPS_CTL_DIODE_LO]
			== `LPS_DIODE_CH1); // [R7]
		s_d.diode_bad = !s_d.diode_ch1; // [R7]

		// wait timer: a start while running is ignored
		unique case (s_q.wst)
			lps_pkg::LPS_W_IDLE:
			begin
				if (wait_start)
				begin
					s_d.wst = lps_pkg::LPS_W_RUN;
					s_d.wtick = 17'h0_0000;
					s_d.wsteps = s_q.cfg[`LPS_CFG_WAIT_EXTEND] ?
						12'(wbase * 12'(`LPS_WAIT_EXTEND)) : wbase; // [R3]
				end
			end
			lps_pkg::LPS_W_RUN:
			begin
				s_d.wtick = s_q.wtick + 17'h0_0001;
				if (s_q.wtick == STEP_M1)
				begin
					s_d.wtick = 17'h0_0000; // [R18]
					s_d.wsteps = s_q.wsteps - 12'h001;
					if (s_q.wsteps == 12'h001)
					begin
						s_d.wst = lps_pkg::LPS_W_IDLE;
						s_d.wait_done = 1'b1;
					end
				end
			end
			default:
				s_d.wst = lps_pkg::LPS_W_IDLE;
		endcase
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.cfg <= `LPS_CONFIG_RST;
			s_q.pulses <= `LPS_PULSES_RST;
			s_q.ctrl <= `LPS_CONTROL_RST;
			s_q.wst <= lps_pkg::LPS_W_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------------------
	// led burst, count taken from the pulse register
	// ------------------------------------------------------------------------
	lps_led_pulser #(
		.PERIOD(PULSE_PERIOD)
	) u_pulser (
		.clk(clk),
		.rst_n(rst_n),
		.start(prox_accum_start),
		.pulse_count(s_q.pulses), // [R5]
		.led_drive_pin(led_drive_pin),
		.busy(pulser_busy),
		.done(prox_pulses_done)
	);

	assign reg_rdata = s_q.rdata;
	assign wait_done = s_q.wait_done;
	assign led_current_ua = s_q.led_ua;
	assign light_gain_x100 = s_q.lgain;
	assign prox_gain = s_q.prox_gain;
	assign prox_diode_ch1 = s_q.diode_ch1;
	assign prox_diode_invalid = s_q.diode_bad;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	sequence low_then_high(logic [7:0] lo, logic [7:0] hi);
		rd_at(lo) ##1 rd_at(hi);
	endsequence

	sequence wr_locked;
		reg_wr && !(reg_addr inside {`LPS_OFF_CONFIG, `LPS_OFF_PULSES,
			`LPS_OFF_CONTROL});
	endsequence

	sequence rd_unmapped;
		reg_rd && !(reg_addr inside {[`LPS_OFF_CONFIG:`LPS_OFF_CONTROL],
			[`LPS_OFF_IDENT:`LPS_OFF_PROX_HI]});
	endsequence

	AST_IDENT_FIXED: assert property ( // [R9]
		rd_at(`LPS_OFF_IDENT) |=> reg_rdata == PART_ID)
		else $error("identity read returned a changed value");

	AST_CFG_RSVD_ZERO: assert property ( // [R19]
		rd_at(`LPS_OFF_CONFIG) |=> reg_rdata[7:3] == 5'h00)
		else $error("configuration reserved bits read non-zero");

	AST_RO_WRITE_IGNORED: assert property ( // [R9] [R19]
		wr_locked |=> $stable(s_q.cfg) && $stable(s_q.pulses)
			&& $stable(s_q.ctrl))
		else $error("write to a read-only offset changed a register");

	AST_UNMAPPED_ZERO: assert property ( // [R19]
		rd_unmapped |=> reg_rdata == 8'h00)
		else $error("unmapped offset read non-zero");

	AST_STATUS_MAP: assert property ( // [R10] [R11] [R12] [R13]
		rd_at(`LPS_OFF_STATUS) |=> reg_rdata == {1'b0,
			$past(prox_saturated), $past(prox_irq_flag),
			$past(light_irq_flag), 2'b00, $past(prox_result_ready),
			$past(light_result_ready)})
		else $error("status read does not match device state");

	AST_SHADOW_CH0: assert property ( // [R16] [R14]
		low_then_high(`LPS_OFF_CH0_LO, `LPS_OFF_CH0_HI)
			|=> reg_rdata == $past(s_q.ch0[15:8], 2))
		else $error("ch0 high byte does not come from the shadow");

	AST_SHADOW_CH1: assert property ( // [R16] [R14]
		low_then_high(`LPS_OFF_CH1_LO, `LPS_OFF_CH1_HI)
			|=> reg_rdata == $past(s_q.ch1[15:8], 2))
		else $error("ch1 high byte does not come from the shadow");

	AST_SHADOW_PROX: assert property ( // [R16] [R15]
		low_then_high(`LPS_OFF_PROX_LO, `LPS_OFF_PROX_HI)
			|=> reg_rdata == $past(s_q.prox[15:8], 2))
		else $error("proximity high byte does not come from the shadow");

	AST_DRIVE_FULL: assert property ( // [R4]
		s_q.ctrl[7:6] == 2'h0 && !s_q.cfg[0] && $stable(s_q.ctrl)
			&& $stable(s_q.cfg) |=> led_current_ua == 17'h1_86a0)
		else $error("drive code 00 does not give 100 mA");

	AST_DRIVE_REDUCED: assert property ( // [R4]
		s_q.ctrl[7:6] == 2'h1 && s_q.cfg[0] && $stable(s_q.ctrl)
			&& $stable(s_q.cfg) |=> led_current_ua == 17'h0_15e0)
		else $error("reduced drive code 01 does not give 5.6 mA");

	AST_GAIN_SCALED: assert property ( // [R2] [R8]
		s_q.cfg[2] && s_q.ctrl[1:0] == 2'h1 && $stable(s_q.ctrl)
			&& $stable(s_q.cfg) |=> light_gain_x100 == 14'h0080)
		else $error("scaled 8x light gain is not 1.28");

	AST_DIODE_DECODE: assert property ( // [R7]
		$past(s_q.ctrl[5:4]) != 2'h2 && $stable(s_q.ctrl)
			|=> prox_diode_invalid && !prox_diode_ch1)
		else $error("reserved diode code not flagged");

	AST_WAIT_LOAD: assert property ( // [R3] [R18]
		wait_start && s_q.wst == lps_pkg::LPS_W_IDLE |=> s_q.wsteps
			== ($past(s_q.cfg[1]) ?
			12'(12'(9'h100 - {1'b0, $past(wait_time)}) * 12'd12) :
			12'(9'h100 - {1'b0, $past(wait_time)})))
		else $error("wait step count not loaded from wait time and extend");

	AST_WAIT_STEP: assert property ( // [R18]
		s_q.wst == lps_pkg::LPS_W_RUN && s_q.wtick == STEP_M1
			&& s_q.wsteps == 12'h001 |=> wait_done ##1 !wait_done)
		else $error("wait end is not a one-cycle pulse after last step");

endmodule : lps_sensor_regs

// File: sim/lps_host_model.sv
// host model driving the byte-wide register port of the sensor block
`timescale 1ns/1ps

module lps_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);

	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// --------------------------------------------------------------------
	// bus cycles, all changes at the falling edge
	// --------------------------------------------------------------------
	// idle bus shows the inverse of the last value, never a stale match
	task automatic release_bus();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask : release_bus

	// raw only where a test means to break the write-zero habit
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input bit raw = 1'b0);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = (a == 8'h0d && !raw) ? (d & 8'h07) : d;
		reg_wr = 1'b1;
		@(negedge clk);
		release_bus();
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		d = reg_rdata;
		release_bus();
	endtask : rd

	// low then high byte back to back, as one two-byte transfer
	task automatic rd2(input logic [7:0] a, output logic [7:0] lo,
		output logic [7:0] hi);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		lo = reg_rdata;
		reg_addr = a + 8'h01;
		@(negedge clk);
		hi = reg_rdata;
		release_bus();
	endtask : rd2

endmodule : lps_host_model

// File: sim/lps_sensor_regs_tb.sv
// self-checking bench for the sensor register block
`timescale 1ns/1ps

module lps_sensor_regs_tb;

	localparam int WSC = 10;
	localparam int PER = 8;
	// arbitrary identity value for this run
	localparam logic [7:0] ID = 8'h3c;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, lo, hi8;
	logic reg_wr, reg_rd, light_update = 1'b0, prox_update = 1'b0;
	logic [15:0] ch0_result = 16'h0000, ch1_result = 16'h0000;
	logic [15:0] prox_result = 16'h0000;
	logic [4:0] st_in = 5'h00;
	logic [7:0] wait_time = 8'h00;
	logic wait_start = 1'b0, prox_accum_start = 1'b0;
	logic led_drive_pin, prox_pulses_done, wait_done;
	logic prox_diode_ch1, prox_diode_invalid;
	logic [16:0] led_current_ua;
	logic [13:0] light_gain_x100;
	logic [3:0] prox_gain;
	int n_errors = 0, cmp_count = 0, cyc = 0, n, hi;
	int full [4] = '{100000, 50000, 25000, 12500};
	int red [4] = '{11100, 5600, 2800, 1400};
	int lg [4] = '{100, 800, 1600, 12000};
	int lgs [2] = '{16, 128};
	int pc [3] = '{0, 3, 8};
	logic [7:0] ra [4] = '{8'h0d, 8'h0e, 8'h0f, 8'h12};
	logic [7:0] rv [4] = '{8'h00, 8'h08, 8'h20, ID};

	always #12.5 clk = ~clk;

	lps_host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	lps_sensor_regs #(.WAIT_STEP_CYCLES(WSC), .PULSE_PERIOD(PER),
		.PART_ID(ID)) dut_u (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ch0_result(ch0_result), .ch1_result(ch1_result),
		.light_update(light_update), .prox_result(prox_result),
		.prox_update(prox_update), .prox_saturated(st_in[4]),
		.prox_irq_flag(st_in[3]), .light_irq_flag(st_in[2]),
		.prox_result_ready(st_in[1]), .light_result_ready(st_in[0]),
		.wait_time(wait_time), .wait_start(wait_start),
		.prox_accum_start(prox_accum_start),
		.led_drive_pin(led_drive_pin), .prox_pulses_done(prox_pulses_done),
		.wait_done(wait_done), .led_current_ua(led_current_ua),
		.light_gain_x100(light_gain_x100), .prox_gain(prox_gain),
		.prox_diode_ch1(prox_diode_ch1),
		.prox_diode_invalid(prox_diode_invalid));

	// --------------------------------------------------------------------
	// compares and closing
	// --------------------------------------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic conclude();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			conclude();
		end
	end

	// --------------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		foreach (ra[k])
		begin
			h.rd(ra[k], lo);
			chk_reg(lo, rv[k]);
		end
		h.wr(8'h0d, 8'hff, 1'b1);
		h.rd(8'h0d, lo);
		chk_reg(lo, 8'h07);
		h.wr(8'h12, ~ID);
		h.rd(8'h12, lo);
		chk_reg(lo, ID);
		for (int r = 0; r < 2; r++)
			for (int i = 0; i < 4; i++)
			begin
				// scale-down only used with gain up to 8x
				if (r == 1 && i > 1)
					continue;
				h.wr(8'h0d, {5'h00, r[0], 1'b0, r[0]});
				h.wr(8'h0f, {i[1:0], i[1:0], i[1:0], i[1:0]});
				repeat (2) @(negedge clk);
				chk_val(32'(led_current_ua), r ? red[i] : full[i]);
				chk_val(32'(light_gain_x100), r ? lgs[i] : lg[i]);
				chk_val(32'(prox_gain), 1 << i);
				chk_val({prox_diode_ch1, prox_diode_invalid},
					(i == 2) ? 2'b10 : 2'b01);
			end
		for (int s = 0; s < 32; s += 7)
		begin
			st_in = s[4:0];
			h.wr(8'h13, 8'hff);
			h.rd(8'h13, lo);
			chk_reg(lo, {1'b0, s[4:2], 2'b00, s[1:0]});
		end
		ch0_result = 16'h1234;
		ch1_result = 16'habcd;
		prox_result = 16'h5678;
		light_update = 1'b1;
		prox_update = 1'b1;
		@(negedge clk);
		light_update = 1'b0;
		prox_update = 1'b0;
		h.wr(8'h14, 8'h00);
		h.rd2(8'h14, lo, hi8);
		chk_val({hi8, lo}, 16'h1234);
		h.rd2(8'h16, lo, hi8);
		chk_val({hi8, lo}, 16'habcd);
		h.rd2(8'h18, lo, hi8);
		chk_val({hi8, lo}, 16'h5678);
		h.rd(8'h14, lo);
		ch0_result = 16'hfe01;
		light_update = 1'b1;
		@(negedge clk);
		light_update = 1'b0;
		h.rd(8'h15, hi8);
		chk_reg(hi8, 8'h12);
		h.rd2(8'h14, lo, hi8);
		chk_val({hi8, lo}, 16'hfe01);
		h.rd(8'h40, lo);
		chk_reg(lo, 8'h00);
		for (int x = 0; x < 2; x++)
		begin
			h.wr(8'h0d, {6'h00, x[0], 1'b0});
			@(negedge clk);
			wait_time = 8'hfe;
			wait_start = 1'b1;
			@(negedge clk);
			wait_start = 1'b0;
			n = 1;
			while (wait_done !== 1'b1 && n < 400)
			begin
				@(negedge clk);
				n++;
			end
			chk_val(n, 2 * WSC * (x ? 12 : 1) + 1);
			@(negedge clk);
			chk_val(wait_done, 1'b0);
		end
		foreach (pc[k])
		begin
			h.wr(8'h0e, 8'(pc[k]));
			@(negedge clk);
			prox_accum_start = 1'b1;
			@(negedge clk);
			prox_accum_start = 1'b0;
			n = 1;
			hi = 0;
			while (prox_pulses_done !== 1'b1 && n < 200)
			begin
				if (led_drive_pin === 1'b1)
					hi++;
				@(negedge clk);
				n++;
			end
			chk_val(n, pc[k] * PER + 1);
			chk_val(hi, pc[k] * PER / 2);
		end
		conclude();
	end

endmodule : lps_sensor_regs_tb
